// ### core/astx_pkg.sv
package astx_pkg;

  // ----------------------------------------------------------------
  // Register word offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] ASTX_OFF_RATE_CFG  = 12'h000;
  localparam logic [11:0] ASTX_OFF_RX_CTRL   = 12'h004;
  localparam logic [11:0] ASTX_OFF_DIV_LOW   = 12'h008;
  localparam logic [11:0] ASTX_OFF_DIV_HIGH  = 12'h00C;
  localparam logic [11:0] ASTX_OFF_HOLDING   = 12'h010;
  localparam logic [11:0] ASTX_OFF_TX_CTRL   = 12'h014;
  localparam logic [11:0] ASTX_OFF_IRQ_CTRL  = 12'h018;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  // transmit_status_control
  localparam int ASTX_TX_NINTH_BIT   = 0;
  localparam int ASTX_TX_EMPTY_BIT   = 1;
  localparam int ASTX_TX_HSPEED_BIT  = 2;
  localparam int ASTX_TX_SYNC_BIT    = 4;
  localparam int ASTX_TX_ENABLE_BIT  = 5;
  localparam int ASTX_TX_NINE_BIT    = 6;
  // receive_status_control
  localparam int ASTX_RX_PORT_ON_BIT = 7;
  // rate_config
  localparam int ASTX_RC_WIDE_BIT    = 3;
  localparam int ASTX_RC_INVERT_BIT  = 4;
  // irq control register of our own
  localparam int ASTX_IRQ_FLAG_BIT   = 0;
  localparam int ASTX_IRQ_EN_BIT     = 1;
  localparam int ASTX_IRQ_PERI_BIT   = 2;
  localparam int ASTX_IRQ_GLOB_BIT   = 3;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] ASTX_RST_BYTE    = 8'h00;
  localparam logic [1:0] ASTX_FLAG_DELAY  = 2'h2; // Instruction cycles to flag validity
  localparam int         ASTX_TCY_CYCLES  = 4;    // Clocks per instruction cycle
  localparam logic [3:0] ASTX_BITS_EIGHT  = 4'h8;
  localparam logic [3:0] ASTX_BITS_NINE   = 4'h9;

  // Character as captured from the holding buffer
  typedef struct packed {
    logic       ninth;
    logic [7:0] data;
  } astx_char_t;

  typedef enum logic [1:0] {ASTX_IDLE, ASTX_START, ASTX_DATA, ASTX_STOP} astx_state_t;

endpackage

// ### core/astx_transmitter.sv
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module astx_transmitter
  import astx_pkg::*;
#(
  parameter int TCY_CYCLES = ASTX_TCY_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        baud_tick,
  output logic             tx_out,
  output logic             tx_oe,
  output logic             tx_irq,
  output logic [15:0]      rate_divisor,
  output logic             high_speed_rate_select,
  output logic             wide_divisor_select
);

  // Divider counter is 8 bits wide, so the ratio must fit in it
  if (TCY_CYCLES < 1 || TCY_CYCLES > 255) begin : g_bad_tcy
    $error("TCY_CYCLES must lie in 1..255");
  end

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic [7:0] rate_config_reg;
  logic [7:0] receive_status_control_reg;
  logic [7:0] rate_divisor_low_reg;
  logic [7:0] rate_divisor_high_reg;
  logic [7:0] transmit_status_control_reg;
  logic [3:0] irq_ctrl_reg;
  logic       acc;
  logic       wr;
  logic       hold_write;

  assign acc        = psel & penable;
  assign wr         = acc & pwrite;
  assign hold_write = wr && (paddr == ASTX_OFF_HOLDING);
  assign pready     = 1'b1; // Zero wait states
  assign pslverr    = 1'b0;

  function automatic logic addr_known(input logic [11:0] a);
    return (a == ASTX_OFF_RATE_CFG) || (a == ASTX_OFF_RX_CTRL) || (a == ASTX_OFF_DIV_LOW)
        || (a == ASTX_OFF_DIV_HIGH) || (a == ASTX_OFF_HOLDING) || (a == ASTX_OFF_TX_CTRL)
        || (a == ASTX_OFF_IRQ_CTRL);
  endfunction

  // Writable control registers; the flag bit is not stored, and the stored empty bit is never read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_config_reg             <= ASTX_RST_BYTE;
      receive_status_control_reg  <= ASTX_RST_BYTE;
      rate_divisor_low_reg        <= ASTX_RST_BYTE;
      rate_divisor_high_reg       <= ASTX_RST_BYTE;
      transmit_status_control_reg <= ASTX_RST_BYTE;
      irq_ctrl_reg                <= 4'h0;
    end else if (wr) begin
      if (paddr == ASTX_OFF_RATE_CFG) begin
        rate_config_reg <= pwdata[7:0];
      end else if (paddr == ASTX_OFF_RX_CTRL) begin
        receive_status_control_reg <= pwdata[7:0];
      end else if (paddr == ASTX_OFF_DIV_LOW) begin
        rate_divisor_low_reg <= pwdata[7:0];
      end else if (paddr == ASTX_OFF_DIV_HIGH) begin
        rate_divisor_high_reg <= pwdata[7:0];
      end else if (paddr == ASTX_OFF_TX_CTRL) begin
        transmit_status_control_reg <= pwdata[7:0];
      end else if (paddr == ASTX_OFF_IRQ_CTRL) begin
        irq_ctrl_reg <= {pwdata[3:1], 1'b0}; // Flag bit is never stored
      end
    end
  end

  logic port_on;
  logic tx_enable;
  logic sync_mode;
  logic nine_bit_select;
  logic ninth_bit_value;
  logic polarity_invert;
  logic active;

  assign port_on         = receive_status_control_reg[ASTX_RX_PORT_ON_BIT];
  assign tx_enable       = transmit_status_control_reg[ASTX_TX_ENABLE_BIT];
  assign sync_mode       = transmit_status_control_reg[ASTX_TX_SYNC_BIT];
  assign nine_bit_select = transmit_status_control_reg[ASTX_TX_NINE_BIT];
  assign ninth_bit_value = transmit_status_control_reg[ASTX_TX_NINTH_BIT];
  assign polarity_invert = rate_config_reg[ASTX_RC_INVERT_BIT];
  assign active          = tx_enable & ~sync_mode & port_on;

  assign rate_divisor           = {rate_divisor_high_reg, rate_divisor_low_reg};
  assign high_speed_rate_select = transmit_status_control_reg[ASTX_TX_HSPEED_BIT];
  assign wide_divisor_select    = rate_config_reg[ASTX_RC_WIDE_BIT];

  // ----------------------------------------------------------------
  // Instruction cycle enable
  // ----------------------------------------------------------------
  logic [7:0] tcy_cnt_reg;
  logic       tcy_tick;
  assign tcy_tick = (tcy_cnt_reg == 8'(TCY_CYCLES - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tcy_cnt_reg <= 8'h00;
    end else if (tcy_tick) begin
      tcy_cnt_reg <= 8'h00;
    end else begin
      tcy_cnt_reg <= tcy_cnt_reg + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Holding buffer and shifter
  // ----------------------------------------------------------------
  astx_char_t  hold_reg;
  logic        hold_full_reg;
  astx_state_t state_reg;
  logic [8:0]  shift_reg;
  logic [3:0]  bit_cnt_reg;
  logic [3:0]  bit_total_reg;
  logic        pending_load_reg; // Stop ended, load on next Tcy
  logic        lead_reg;         // Idle load holds mark until a tick; costs up to one bit of latency
  logic        shifter_empty;
  logic        stop_done;
  logic        load_now;
  logic        load_from_write;
  astx_char_t  load_char;

  assign shifter_empty   = (state_reg == ASTX_IDLE) & ~pending_load_reg;
  assign stop_done       = (state_reg == ASTX_STOP) & baud_tick;
  // Idle shifter takes the write directly; busy one defers
  assign load_from_write = active & hold_write & shifter_empty & ~hold_full_reg;
  assign load_now        = load_from_write | (pending_load_reg & tcy_tick);
  assign load_char       = load_from_write ? astx_char_t'({ninth_bit_value, pwdata[7:0]})
                                           : hold_reg;

  // Holding buffer: captures all nine bits at the write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_reg      <= '0;
      hold_full_reg <= 1'b0;
    end else if (!active) begin
      hold_full_reg <= 1'b0;
    end else if (hold_write && !load_from_write) begin
      hold_reg      <= astx_char_t'({ninth_bit_value, pwdata[7:0]});
      hold_full_reg <= 1'b1;
    end else if (load_now) begin
      hold_full_reg <= 1'b0;
    end
  end

  // Deferred transfer waits for the tick ending the stop bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending_load_reg <= 1'b0;
    end else if (!active) begin
      pending_load_reg <= 1'b0;
    end else if (pending_load_reg && tcy_tick) begin
      pending_load_reg <= 1'b0;
    end else if (stop_done && hold_full_reg) begin
      pending_load_reg <= 1'b1;
    end
  end

  // Shifter: start, data LSB first, stop, one baud tick each
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg     <= ASTX_IDLE;
      shift_reg     <= '0;
      bit_cnt_reg   <= 4'h0;
      bit_total_reg <= ASTX_BITS_EIGHT;
      lead_reg      <= 1'b0;
    end else if (!active) begin
      state_reg <= ASTX_IDLE;
      lead_reg  <= 1'b0;
    end else if (load_now) begin
      state_reg     <= ASTX_START;
      shift_reg     <= {load_char.ninth, load_char.data};
      bit_cnt_reg   <= 4'h0;
      bit_total_reg <= nine_bit_select ? ASTX_BITS_NINE : ASTX_BITS_EIGHT;
      lead_reg      <= load_from_write; // Deferred loads already sit on a bit boundary
    end else if (baud_tick) begin
      case (state_reg)
        ASTX_START: begin
          if (lead_reg) begin
            lead_reg <= 1'b0; // Start bit begins here and lasts a full period
          end else begin
            state_reg <= ASTX_DATA;
          end
        end
        ASTX_DATA: begin
          shift_reg   <= {1'b0, shift_reg[8:1]};
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
          if (bit_cnt_reg == bit_total_reg - 4'h1) begin
            state_reg <= ASTX_STOP;
          end
        end
        ASTX_STOP: begin
          state_reg <= ASTX_IDLE;
        end
        default: begin
          state_reg <= ASTX_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Line output
  // ----------------------------------------------------------------
  logic line_level;
  always_comb begin
    case (state_reg)
      ASTX_START: line_level = lead_reg;     // Mark while waiting, then space
      ASTX_DATA:  line_level = shift_reg[0];
      default:    line_level = 1'b1;         // Mark for idle and stop
    endcase
  end

  // Registered so the pin never glitches on state decode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_out <= 1'b1;
      tx_oe  <= 1'b0;
    end else begin
      tx_out <= line_level ^ (polarity_invert & ~sync_mode);
      tx_oe  <= port_on;
    end
  end

  // ----------------------------------------------------------------
  // Buffer-free flag with two-Tcy settle after a write
  // ----------------------------------------------------------------
  logic       flag_reg;
  logic [1:0] flag_wait_reg;
  logic       flag_true;

  assign flag_true = active & ~hold_full_reg;

  // Flag lags a write until the second Tcy boundary, else tracks at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_reg      <= 1'b0;
      flag_wait_reg <= 2'h0;
    end else if (hold_write && active) begin
      flag_wait_reg <= ASTX_FLAG_DELAY;
    end else if (flag_wait_reg != 2'h0) begin
      if (tcy_tick) begin
        flag_wait_reg <= flag_wait_reg - 2'h1;
        if (flag_wait_reg == 2'h1) begin
          flag_reg <= flag_true;
        end
      end
    end else begin
      flag_reg <= flag_true;
    end
  end

  // Interrupt gated by all three enables; shifter-empty never feeds it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_irq <= 1'b0;
    end else begin
      tx_irq <= flag_reg & irq_ctrl_reg[ASTX_IRQ_EN_BIT] & irq_ctrl_reg[ASTX_IRQ_PERI_BIT]
              & irq_ctrl_reg[ASTX_IRQ_GLOB_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [7:0] tx_status_view;
  logic [3:0] irq_view;
  always_comb begin
    tx_status_view = transmit_status_control_reg;
    tx_status_view[ASTX_TX_EMPTY_BIT] = shifter_empty;
    irq_view = irq_ctrl_reg;
    irq_view[ASTX_IRQ_FLAG_BIT] = flag_reg;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      if (paddr == ASTX_OFF_RATE_CFG) begin
        prdata <= {24'h000000, rate_config_reg};
      end else if (paddr == ASTX_OFF_RX_CTRL) begin
        prdata <= {24'h000000, receive_status_control_reg};
      end else if (paddr == ASTX_OFF_DIV_LOW) begin
        prdata <= {24'h000000, rate_divisor_low_reg};
      end else if (paddr == ASTX_OFF_DIV_HIGH) begin
        prdata <= {24'h000000, rate_divisor_high_reg};
      end else if (paddr == ASTX_OFF_TX_CTRL) begin
        prdata <= {24'h000000, tx_status_view};
      end else if (paddr == ASTX_OFF_IRQ_CTRL) begin
        prdata <= {28'h0000000, irq_view};
      end else begin
        prdata <= 32'h0000_0000; // Holding buffer and unmapped read zero
      end
    end
  end

  logic unused_ok;
  assign unused_ok = addr_known(paddr);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_stop_end;
    (state_reg == ASTX_STOP) && baud_tick && hold_full_reg && active;
  endsequence

  a_idle_load: assert property (@(posedge pclk) disable iff (!presetn)
    load_from_write |=> state_reg == ASTX_START && !hold_full_reg)
    else $error("idle shifter did not take write");
  a_pending_load: assert property (@(posedge pclk) disable iff (!presetn)
    s_stop_end |=> ##[0:255] (state_reg == ASTX_START))
    else $error("held character not loaded after stop");
  a_inactive_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !active |=> state_reg == ASTX_IDLE && !hold_full_reg)
    else $error("transmitter not reset when off");
  a_oe_follow: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> tx_oe == $past(port_on))
    else $error("pin direction wrong");
  // Line register uses the polarity of the cycle before, so compare against $past
  a_start_space: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == ASTX_START && !lead_reg && !sync_mode
      |=> tx_out == $past(polarity_invert))
    else $error("start bit not space");
  a_idle_mark: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == ASTX_IDLE && !sync_mode
      |=> tx_out == !$past(polarity_invert))
    else $error("idle level wrong");
  a_flag_lag: assert property (@(posedge pclk) disable iff (!presetn)
    hold_write && active && flag_reg |=> flag_reg)
    else $error("flag fell at once");
  a_flag_low: assert property (@(posedge pclk) disable iff (!presetn)
    !flag_reg && flag_wait_reg == 2'h0 && $past(flag_wait_reg) == 2'h0
      |-> $past(hold_full_reg) || !$past(active))
    else $error("flag low without pending char");
  a_empty_load: assert property (@(posedge pclk) disable iff (!presetn)
    load_now && active |=> !shifter_empty)
    else $error("shifter empty after load");
  a_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
    tx_irq |-> $past(flag_reg) && $past(irq_ctrl_reg[ASTX_IRQ_EN_BIT]))
    else $error("interrupt without flag and enable");

endmodule

// ### testbench/astx_rx_model.sv
`timescale 1ns/1ps
module astx_rx_model
  import astx_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        baud_tick,
  input  wire logic        line_in,
  input  wire logic        nine_bits,
  input  wire logic        invert,
  input  wire logic        rx_clr,
  output logic             got,
  output astx_char_t       rx_char,
  output logic             frame_ok,
  output logic [3:0]       gap_ticks
);
  logic       busy_reg;
  logic [3:0] bit_reg;
  logic [3:0] idle_reg;
  logic [8:0] shift_reg;
  logic       tick_d1;
  logic       tick_d2;
  logic       level;

  // ----------------------------------------------------------------
  // Line sampling
  // ----------------------------------------------------------------
  // Receiver is set up for the same polarity, so mark reads as 1
  assign level = line_in ^ invert;

  // Sample two clocks after each tick; ticks before the start edge are not armed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_d1 <= 1'b0;
      tick_d2 <= 1'b0;
    end else begin
      tick_d1 <= baud_tick & busy_reg;
      tick_d2 <= tick_d1;
    end
  end

  // ----------------------------------------------------------------
  // Frame decoding
  // ----------------------------------------------------------------
  // Idle ticks are counted so the bench can see gaps between characters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_reg  <= 1'b0;
      bit_reg   <= 4'h0;
      idle_reg  <= 4'h0;
      shift_reg <= 9'h000;
      got       <= 1'b0;
      rx_char   <= '0;
      frame_ok  <= 1'b0;
      gap_ticks <= 4'h0;
    end else if (rx_clr) begin
      busy_reg <= 1'b0;
      idle_reg <= 4'h0;
      got      <= 1'b0;
    end else begin
      got <= 1'b0;
      if (!busy_reg) begin
        if (baud_tick && idle_reg != 4'hF) begin
          idle_reg <= idle_reg + 4'h1;
        end
        if (!level) begin
          busy_reg  <= 1'b1;
          bit_reg   <= 4'h0;
          gap_ticks <= idle_reg;
          idle_reg  <= 4'h0;
        end
      end else if (tick_d2) begin
        if (bit_reg < (nine_bits ? 4'h9 : 4'h8)) begin
          shift_reg[bit_reg] <= level;
          bit_reg            <= bit_reg + 4'h1;
        end else begin
          busy_reg <= 1'b0;
          got      <= 1'b1;
          frame_ok <= level;
          rx_char  <= astx_char_t'(nine_bits ? shift_reg : {1'b0, shift_reg[7:0]});
        end
      end
    end
  end
endmodule

// ### testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import astx_pkg::*;
();
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        baud_tick;
  logic [3:0]  baud_cnt;
  logic        tx_out;
  logic        tx_oe;
  logic        tx_irq;
  logic [15:0] rate_divisor;
  logic        hs_sel;
  logic        wide_sel;
  logic        rx_nine;
  logic        rx_inv;
  logic        rx_clr;
  logic        got;
  astx_char_t  rx_char;
  logic        frame_ok;
  logic [3:0]  gap_ticks;
  astx_char_t  rx_q[$];
  logic [3:0]  gap_q[$];
  int          n_fail;
  int          total_checks;
  int          seed;

  astx_transmitter i_astx_transmitter (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .baud_tick(baud_tick), .tx_out(tx_out),
    .tx_oe(tx_oe), .tx_irq(tx_irq), .rate_divisor(rate_divisor),
    .high_speed_rate_select(hs_sel), .wide_divisor_select(wide_sel));

  astx_rx_model i_astx_rx_model (.pclk(pclk), .presetn(presetn), .baud_tick(baud_tick),
    .line_in(tx_out), .nine_bits(rx_nine), .invert(rx_inv), .rx_clr(rx_clr), .got(got),
    .rx_char(rx_char), .frame_ok(frame_ok), .gap_ticks(gap_ticks));

  // ----------------------------------------------------------------
  // Clock, bit rate and collection
  // ----------------------------------------------------------------
  always #4 pclk = ~pclk;

  // One tick every 16 clocks keeps each character short
  always @(posedge pclk) begin
    baud_cnt  <= baud_cnt + 4'h1;
    baud_tick <= (baud_cnt == 4'hE);
  end

  always @(posedge pclk) begin
    if (got === 1'b1) begin
      rx_q.push_back(rx_char);
      gap_q.push_back(gap_ticks);
      check("stop bit", {31'h0, frame_ok}, 32'h1);
    end
  end

  // Hang guard, far beyond the few thousand cycles the sequence needs
  initial begin
    repeat (30000) @(posedge pclk);
    n_fail++;
    print_verdict();
  end

  // ----------------------------------------------------------------
  // Tasks and expectations
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Request held until pready is seen high; an idle edge lets outputs settle
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [7:0] data,
                     output logic [31:0] rd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= {24'h0, data};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] addr, input logic [7:0] data);
    logic [31:0] d;
    apb(1'b1, addr, data, d);
  endtask

  task automatic rd_chk(input string what, input logic [11:0] addr, input logic [7:0] exp);
    logic [31:0] d;
    apb(1'b0, addr, 8'h00, d);
    check(what, d, {24'h0, exp});
  endtask

  function automatic logic [7:0] txc(input logic nine, input logic ninth);
    return {1'b0, nine, 1'b1, 4'h0, ninth};
  endfunction

  // Ninth bit only travels in nine-bit mode
  function automatic logic [31:0] exp_char(input logic nine, input logic [8:0] c);
    return {23'h0, nine & c[8], c[7:0]};
  endfunction

  task automatic send(input logic nine, input logic [8:0] c);
    wr(ASTX_OFF_TX_CTRL, txc(nine, c[8]));
    wr(ASTX_OFF_HOLDING, c[7:0]);
  endtask

  task automatic restart_rx();
    rx_clr <= 1'b1;
    @(posedge pclk);
    rx_clr <= 1'b0;
    rx_q.delete();
    gap_q.delete();
  endtask

  task automatic wait_rx(input int n);
    for (int k = 0; k < 2000 && rx_q.size() < n; k++) @(posedge pclk);
  endtask

  task automatic print_verdict();
    if (n_fail == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] v;
    logic [7:0] w;
    logic [8:0] c1;
    logic [8:0] c2;
    logic [2:0] irqv;
    logic       nine;
    logic       inv;
    seed = 32'h6aef;
    n_fail = 0;
    total_checks = 0;
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {baud_cnt, baud_tick, rx_nine, rx_inv, rx_clr} = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) rd_chk("reset value", 12'(4 * i), i == 5 ? 8'h02 : 8'h00);
    check("reset pin", {30'h0, tx_oe, tx_out}, 32'h1);
    v = 8'($random(seed));
    w = 8'($random(seed));
    wr(ASTX_OFF_DIV_LOW, v);
    wr(ASTX_OFF_DIV_HIGH, w);
    rd_chk("divisor low", ASTX_OFF_DIV_LOW, v);
    rd_chk("divisor high", ASTX_OFF_DIV_HIGH, w);
    wr(ASTX_OFF_RATE_CFG, 8'h08);
    wr(ASTX_OFF_TX_CTRL, 8'h04);
    check("rate outputs", {14'h0, hs_sel, wide_sel, rate_divisor}, {16'h3, w, v});
    wr(12'h01C, 8'hFF);
    rd_chk("unmapped", 12'h01C, 8'h00);
    wr(ASTX_OFF_IRQ_CTRL, 8'h01);
    rd_chk("flag write", ASTX_OFF_IRQ_CTRL, 8'h00);
    wr(ASTX_OFF_RATE_CFG, 8'h00);
    // Third pass is sync mode with invert set: line must stay high and silent
    for (int i = 0; i < 3; i++) begin
      wr(ASTX_OFF_RX_CTRL, i ? 8'h80 : 8'h00);
      wr(ASTX_OFF_TX_CTRL, (i == 0) ? 8'h20 : ((i == 1) ? 8'h00 : 8'h30));
      wr(ASTX_OFF_RATE_CFG, {3'h0, i == 2, 4'h0});
      wr(ASTX_OFF_HOLDING, 8'h5A);
      repeat (250) @(posedge pclk);
      check("inactive send", {31'h0, tx_out}, 32'h1);
      check("inactive count", 32'(rx_q.size()), 32'h0);
    end
    wr(ASTX_OFF_RATE_CFG, 8'h00);
    check("pin enable", {31'h0, tx_oe}, 32'h1);
    wr(ASTX_OFF_TX_CTRL, 8'h20);
    rd_chk("flag on enable", ASTX_OFF_IRQ_CTRL, 8'h01);
    for (int it = 0; it < 6; it++) begin
      nine = it[0];
      inv  = (it >= 3);
      irqv = 3'($random(seed));
      c1   = (it == 1) ? 9'h1FF : 9'($random(seed));
      c2   = (it == 1) ? 9'h100 : 9'($random(seed));
      wr(ASTX_OFF_RATE_CFG, {3'h0, inv, 4'h0});
      rx_inv  <= inv;
      rx_nine <= nine;
      restart_rx();
      wr(ASTX_OFF_IRQ_CTRL, {4'h0, irqv, 1'b0});
      @(posedge pclk);
      check("idle level", {31'h0, tx_out}, {31'h0, ~inv});
      check("irq idle", {31'h0, tx_irq}, {31'h0, &irqv});
      rd_chk("flag enables", ASTX_OFF_IRQ_CTRL, {4'h0, irqv, 1'b1});
      send(nine, c1);
      send(nine, c2);
      rd_chk("flag stale", ASTX_OFF_IRQ_CTRL, {4'h0, irqv, 1'b1});
      wr(ASTX_OFF_IRQ_CTRL, {4'h0, irqv[2:1], 2'b00});
      rd_chk("flag pending", ASTX_OFF_IRQ_CTRL, {4'h0, irqv[2:1], 2'b00});
      check("irq pending", {31'h0, tx_irq}, 32'h0);
      rd_chk("shifter busy", ASTX_OFF_TX_CTRL, txc(nine, c2[8]));
      wait_rx(2);
      check("char count", 32'(rx_q.size()), 32'h2);
      check("first char", {23'h0, rx_q[0]}, exp_char(nine, c1));
      check("second char", {23'h0, rx_q[1]}, exp_char(nine, c2));
      check("no gap", {28'h0, gap_q[1]}, 32'h1);
      repeat (40) @(posedge pclk);
      rd_chk("shifter empty", ASTX_OFF_TX_CTRL, txc(nine, c2[8]) | 8'h02);
      rd_chk("flag free", ASTX_OFF_IRQ_CTRL, {4'h0, irqv[2:1], 2'b01});
    end
    rx_nine <= 1'b0;
    send(1'b0, 9'h0A5);
    repeat (60) @(posedge pclk);
    wr(ASTX_OFF_RX_CTRL, 8'h00);
    repeat (2) @(posedge pclk);  // Line settles two registers behind, enable one
    check("abort line", {30'h0, tx_oe, tx_out}, 32'h0);
    rd_chk("abort empty", ASTX_OFF_TX_CTRL, 8'h22);
    wr(ASTX_OFF_RX_CTRL, 8'h80);
    restart_rx();
    send(1'b0, 9'h03C);
    wait_rx(1);
    check("after abort", {23'h0, rx_q.pop_front()}, 32'h03C);
    print_verdict();
  end
endmodule
